// file: core/sfp_pkg.sv
// Purpose: Shared constants for the 18-bit buffer with programmable flags
// Assumes: Pin clocks run far slower than i_clock and are sampled as data
// Notes:   Rules carried by the design and bench follow
package sfp_pkg;
    localparam int SFP_DATA_W      = 18;
    localparam int SFP_OFF_W       = 14;
    localparam int SFP_DEPTH_SMALL = 8192;
    localparam int SFP_DEPTH_LARGE = 16384;
    localparam logic [13:0] SFP_OFF_DEFAULT = 14'h007F;

    // Clock period and asynchronous flag settle time
    localparam int SFP_CLK_NS    = 5;
    localparam int SFP_SETTLE_NS = 5;
    localparam logic [1:0] SFP_SETTLE_CYC =
        2'((SFP_SETTLE_NS + SFP_CLK_NS - 1) / SFP_CLK_NS);

    // Bit positions in the synchronised control vector
    localparam int SFP_C_WCLK  = 0;
    localparam int SFP_C_RCLK  = 1;
    localparam int SFP_C_WEN_N = 2;
    localparam int SFP_C_REN_N = 3;
    localparam int SFP_C_LD_N  = 4;
    localparam int SFP_C_OE_N  = 5;
    localparam int SFP_C_FSYNC = 6;
    localparam int SFP_C_RT    = 7;
    localparam int SFP_C_CASC  = 8;
    localparam int SFP_C_W     = 9;
    // Enables and load idle high at reset
    localparam logic [8:0] SFP_C_RST = 9'h03C;

    typedef enum logic {
        SFP_SEL_EMPTY = 1'b0,
        SFP_SEL_FULL  = 1'b1
    } sfp_sel_t;
endpackage

// file: core/sfp_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Each bit is an independent level from outside the clock domain
// Notes:   Output bit follows only when stages two and three agree
module sfp_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         i_clock,
    input  wire logic         i_reset_n,
    input  wire logic         i_clock_en,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sfp_sync_t;

    sfp_sync_t st_ff;
    sfp_sync_t nxt_st;
    logic [W-1:0] agree;

    always_comb begin
        nxt_st    = st_ff;
        agree     = ~(st_ff.s2 ^ st_ff.s3);
        nxt_st.s1 = i_async;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.q  = (st_ff.q & ~agree) | (st_ff.s3 & agree);
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_ff <= '{s1: RST, s2: RST, s3: RST, q: RST};
        end else if (i_clock_en) begin
            st_ff <= nxt_st;
        end
    end

    assign o_sync = st_ff.q;
endmodule

// file: core/sfp_mem.sv
// Purpose: Dual-port word store with registered read data
// Assumes: One write and one read per cycle at most
// Notes:   Array is not reset; contents are undefined until written
module sfp_mem #(
    parameter int DW = 18,
    parameter int AW = 13
) (
    input  wire logic          i_clock,
    input  wire logic          i_reset_n,
    input  wire logic          i_clock_en,
    input  wire logic          i_wr_en,
    input  wire logic [AW-1:0] i_wr_addr,
    input  wire logic [DW-1:0] i_wr_data,
    input  wire logic          i_rd_en,
    input  wire logic [AW-1:0] i_rd_addr,
    output logic      [DW-1:0] o_rd_data
);
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rd_ff;
    logic [DW-1:0] nxt_rd;

    always_comb begin
        nxt_rd = i_rd_en ? mem[i_rd_addr] : rd_ff;
    end

    always_ff @(posedge i_clock) begin
        if (i_clock_en && i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_ff <= '0;
        end else if (i_clock_en) begin
            rd_ff <= nxt_rd;
        end
    end

    assign o_rd_data = rd_ff;
endmodule

// file: core/sfp_fifo.sv
// Purpose: 18-bit first-in first-out buffer with programmable flags
// Assumes: Pin clocks are sampled on i_clock; at most one edge per 4 cycles
// Notes:   All flags active low; read data has a separate drive enable
module sfp_fifo #(
    parameter int DEPTH = sfp_pkg::SFP_DEPTH_SMALL
) (
    input  wire logic                          i_clock,
    input  wire logic                          i_reset_n,
    input  wire logic                          i_clock_en,
    input  wire logic                          i_write_clock,
    input  wire logic                          i_read_clock,
    input  wire logic                          i_write_enable_n,
    input  wire logic                          i_read_enable_n,
    input  wire logic                          i_offset_load_sel_n,
    input  wire logic                          i_output_drive_en_n,
    input  wire logic                          i_flag_sync_select,
    input  wire logic                          i_replay_strobe,
    input  wire logic                          i_cascaded,
    input  wire logic [sfp_pkg::SFP_DATA_W-1:0] i_write_data_in,
    output logic      [sfp_pkg::SFP_DATA_W-1:0] o_read_data_out,
    output logic                               o_read_data_oe_n,
    output logic                               o_empty_flag_n,
    output logic                               o_full_flag_n,
    output logic                               o_almost_empty_flag_n,
    output logic                               o_almost_full_flag_n,
    output logic                               o_half_full_flag_n
);
    import sfp_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int DW = SFP_DATA_W;
    localparam int OW = SFP_OFF_W;
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW:0] HALF_C  = (AW+1)'(DEPTH / 2);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic          wclk_prev;
        logic          rclk_prev;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0]   count;
        logic          full_n;
        logic          empty_n;
        logic          ae_n;
        logic          af_n;
        logic          hf_n;
        logic [OW-1:0] ae_off;
        logic [OW-1:0] af_off;
        sfp_sel_t      wsel;
        sfp_sel_t      rsel;
        logic          rd_pend;
        logic [DW-1:0] dout;
        logic          oe_n;
        logic [1:0]    settle;
    } sfp_state_t;

    sfp_state_t st_ff;
    sfp_state_t nxt_st;

    logic [SFP_C_W-1:0] ctl;
    logic [DW-1:0]      wdata;
    logic [DW-1:0]      mem_q;
    logic               wr_rise;
    logic               rd_rise;
    logic               wr_go;
    logic               rd_go;
    logic               ld_wr;
    logic               ld_rd;
    logic               replay;
    logic               fsync_n;
    logic [AW:0]        cnt_nxt;
    logic [AW:0]        af_level;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    sfp_sync #(
        .W   (SFP_C_W),
        .RST (SFP_C_RST)
    ) u_ctl_sync (
        .i_clock    (i_clock),
        .i_reset_n  (i_reset_n),
        .i_clock_en (i_clock_en),
        .i_async    ({i_cascaded, i_replay_strobe, i_flag_sync_select,
                      i_output_drive_en_n, i_offset_load_sel_n,
                      i_read_enable_n, i_write_enable_n,
                      i_read_clock, i_write_clock}),
        .o_sync     (ctl)
    );

    // Data rides through the same depth so it lines up with the clock edge
    sfp_sync #(
        .W   (DW),
        .RST ('0)
    ) u_data_sync (
        .i_clock    (i_clock),
        .i_reset_n  (i_reset_n),
        .i_clock_en (i_clock_en),
        .i_async    (i_write_data_in),
        .o_sync     (wdata)
    );

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    sfp_mem #(
        .DW (DW),
        .AW (AW)
    ) u_mem (
        .i_clock    (i_clock),
        .i_reset_n  (i_reset_n),
        .i_clock_en (i_clock_en),
        .i_wr_en    (wr_go),
        .i_wr_addr  (st_ff.wptr),
        .i_wr_data  (wdata),
        .i_rd_en    (rd_go),
        .i_rd_addr  (st_ff.rptr),
        .o_rd_data  (mem_q)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st  = st_ff;
        wr_rise = ctl[SFP_C_WCLK] & ~st_ff.wclk_prev;
        rd_rise = ctl[SFP_C_RCLK] & ~st_ff.rclk_prev;
        replay  = ctl[SFP_C_RT];
        fsync_n = ~ctl[SFP_C_FSYNC];
        // Writes blocked while full, reads while empty
        wr_go   = wr_rise & ~ctl[SFP_C_WEN_N] & ctl[SFP_C_LD_N]
                & st_ff.full_n & ~replay;
        rd_go   = rd_rise & ~ctl[SFP_C_REN_N] & ctl[SFP_C_LD_N]
                & st_ff.empty_n & ~replay;
        ld_wr   = wr_rise & ~ctl[SFP_C_WEN_N] & ~ctl[SFP_C_LD_N];
        ld_rd   = rd_rise & ~ctl[SFP_C_REN_N] & ~ctl[SFP_C_LD_N];
        cnt_nxt = st_ff.count + (AW+1)'(wr_go) - (AW+1)'(rd_go);
        if (replay) begin
            // A full wrap leaves the write pointer at zero: whole depth
            cnt_nxt = (st_ff.wptr == '0) ? DEPTH_C
                                         : {1'b0, st_ff.wptr};
        end
        af_level = DEPTH_C - (AW+1)'(st_ff.af_off);

        nxt_st.wclk_prev = ctl[SFP_C_WCLK];
        nxt_st.rclk_prev = ctl[SFP_C_RCLK];
        nxt_st.count     = cnt_nxt;
        if (wr_go) begin
            nxt_st.wptr = st_ff.wptr + AW'(1);
        end
        if (rd_go) begin
            nxt_st.rptr = st_ff.rptr + AW'(1);
        end
        if (replay) begin
            nxt_st.rptr = '0;
        end

        // Boundary flags move only on their own port edge
        if (wr_rise) begin
            nxt_st.full_n = (cnt_nxt != DEPTH_C);
        end
        if (rd_rise) begin
            nxt_st.empty_n = (cnt_nxt != '0);
        end

        // Almost flags: edge-timed or free-running after settle
        // Both ports are sampled in one domain, so no edge slips
        if (ld_wr) begin
            nxt_st.settle = SFP_SETTLE_CYC;
        end else if (st_ff.settle != '0) begin
            nxt_st.settle = st_ff.settle - 2'(1);
        end
        if ((fsync_n && rd_rise)
                || (!fsync_n && st_ff.settle == '0)) begin
            nxt_st.ae_n = (cnt_nxt > (AW+1)'(st_ff.ae_off));
        end
        if ((fsync_n && wr_rise)
                || (!fsync_n && st_ff.settle == '0)) begin
            nxt_st.af_n = (cnt_nxt < af_level);
        end
        nxt_st.hf_n = (cnt_nxt <= HALF_C);

        // Offset registers share one alternating sequence per port
        if (ld_wr) begin
            case (st_ff.wsel)
                SFP_SEL_EMPTY: begin
                    nxt_st.ae_off = wdata[OW-1:0];
                    nxt_st.wsel   = SFP_SEL_FULL;
                end
                SFP_SEL_FULL: begin
                    nxt_st.af_off = wdata[OW-1:0];
                    nxt_st.wsel   = SFP_SEL_EMPTY;
                end
                default: begin
                    nxt_st.wsel = SFP_SEL_EMPTY;
                end
            endcase
        end

        // Output register holds the last good word when reads stall
        nxt_st.rd_pend = rd_go;
        if (st_ff.rd_pend) begin
            nxt_st.dout = mem_q;
        end
        if (ld_rd) begin
            case (st_ff.rsel)
                SFP_SEL_EMPTY: begin
                    nxt_st.dout = DW'(st_ff.ae_off);
                    nxt_st.rsel = SFP_SEL_FULL;
                end
                SFP_SEL_FULL: begin
                    nxt_st.dout = DW'(st_ff.af_off);
                    nxt_st.rsel = SFP_SEL_EMPTY;
                end
                default: begin
                    nxt_st.rsel = SFP_SEL_EMPTY;
                end
            endcase
        end

        // In a chain only the read-enabled device may drive
        nxt_st.oe_n = ctl[SFP_C_OE_N]
                    | (ctl[SFP_C_CASC] & ctl[SFP_C_REN_N]);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_ff <= '{wclk_prev: 1'b0, rclk_prev: 1'b0,
                       wptr: '0, rptr: '0, count: '0,
                       full_n: 1'b1, empty_n: 1'b0,
                       ae_n: 1'b0, af_n: 1'b1, hf_n: 1'b1,
                       ae_off: SFP_OFF_DEFAULT,
                       af_off: SFP_OFF_DEFAULT,
                       wsel: SFP_SEL_EMPTY, rsel: SFP_SEL_EMPTY,
                       rd_pend: 1'b0, dout: '0,
                       oe_n: 1'b1, settle: 2'h0};
        end else if (i_clock_en) begin
            st_ff <= nxt_st;
        end
    end

    assign o_read_data_out       = st_ff.dout;
    assign o_read_data_oe_n      = st_ff.oe_n;
    assign o_empty_flag_n        = st_ff.empty_n;
    assign o_full_flag_n         = st_ff.full_n;
    assign o_almost_empty_flag_n = st_ff.ae_n;
    assign o_almost_full_flag_n  = st_ff.af_n;
    assign o_half_full_flag_n    = st_ff.hf_n;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_read_take;
        i_clock_en && rd_go;
    endsequence

    sequence s_read_land;
        st_ff.rd_pend ##1 (o_read_data_out == $past(mem_q));
    endsequence

    a_read_lands: assert property (
        s_read_take ##1 i_clock_en |-> s_read_land
    ) else $error("read word did not reach output register");

    a_full_blocks: assert property (
        i_clock_en && wr_rise && !o_full_flag_n |=> $stable(st_ff.wptr)
    ) else $error("write accepted while full");

    a_full_timing: assert property (
        $changed(o_full_flag_n) |-> $past(wr_rise)
    ) else $error("full flag moved without write edge");

    a_empty_timing: assert property (
        $changed(o_empty_flag_n) |-> $past(rd_rise)
    ) else $error("empty flag moved without read edge");

    a_empty_holds: assert property (
        i_clock_en && !o_empty_flag_n && ctl[SFP_C_LD_N]
            && !st_ff.rd_pend |=> $stable(o_read_data_out)
    ) else $error("output changed while empty");

    a_offset_alt: assert property (
        i_clock_en && ld_wr |=> st_ff.wsel != $past(st_ff.wsel)
    ) else $error("offset write sequence did not advance");

    a_ae_level: assert property (
        i_clock_en && fsync_n && rd_rise
            |=> o_almost_empty_flag_n
                == ($past(cnt_nxt) > (AW+1)'($past(st_ff.ae_off)))
    ) else $error("almost empty flag wrong level");

    a_af_level: assert property (
        i_clock_en && fsync_n && wr_rise
            |=> o_almost_full_flag_n == ($past(cnt_nxt) < $past(af_level))
    ) else $error("almost full flag wrong level");

    a_first_word: assert property (
        $rose(o_empty_flag_n) |-> st_ff.count != '0
    ) else $error("empty flag rose with nothing stored");

    a_drive_cut: assert property (
        i_clock_en && ctl[SFP_C_OE_N] |=> o_read_data_oe_n
    ) else $error("outputs driven while drive enable high");

    a_oe_cascade: assert property (
        i_clock_en && ctl[SFP_C_CASC] && ctl[SFP_C_REN_N]
            |=> o_read_data_oe_n
    ) else $error("chained device drove while not read enabled");

    a_empty_blocks: assert property (
        i_clock_en && rd_rise && !o_empty_flag_n && !replay
            |=> $stable(st_ff.rptr)
    ) else $error("read accepted while empty");

    a_write_advance: assert property (
        i_clock_en && wr_go |=> st_ff.wptr == $past(st_ff.wptr) + AW'(1)
    ) else $error("write pointer did not advance by one");

    a_replay_ptr: assert property (
        i_clock_en && replay |=> st_ff.rptr == '0
    ) else $error("replay left read pointer away from zero");

    a_offset_load: assert property (
        i_clock_en && ld_wr && st_ff.wsel == SFP_SEL_EMPTY
            |=> st_ff.ae_off == $past(wdata[OW-1:0])
    ) else $error("empty offset not loaded from low data bits");

    a_offset_out: assert property (
        i_clock_en && ld_rd && st_ff.rsel == SFP_SEL_FULL
            |=> o_read_data_out == DW'($past(st_ff.af_off))
    ) else $error("full offset not placed on read data");
endmodule

// file: test/sfp_agent_model.sv
// Purpose: Writing and reading controller model for the buffer pins
// Assumes: Pin clock high for 4 system cycles, then low for at least 9
// Notes:   Controls stay steady 4 cycles around every pin clock rise
module sfp_agent_model (
    input  wire logic                          i_clock,
    output logic                               o_write_clock,
    output logic                               o_read_clock,
    output logic                               o_write_enable_n,
    output logic                               o_read_enable_n,
    output logic                               o_offset_load_sel_n,
    output logic [sfp_pkg::SFP_DATA_W-1:0]     o_write_data
);
    timeunit 1ns;
    timeprecision 100ps;
    import sfp_pkg::*;

    // ------------------------------------------------------------
    // Pin access
    // ------------------------------------------------------------
    // Idle levels from time zero, so nothing is requested in reset
    initial begin
        o_write_clock       = 1'b0;
        o_read_clock        = 1'b0;
        o_write_enable_n    = 1'b1;
        o_read_enable_n     = 1'b1;
        o_offset_load_sel_n = 1'b1;
        o_write_data        = '0;
    end

    task automatic pin_op(input logic rd, input logic en_n,
                          input logic ld_n,
                          input logic [SFP_DATA_W-1:0] d);
        @(posedge i_clock);
        o_offset_load_sel_n <= ld_n;
        o_write_data        <= d;
        if (rd) begin
            o_read_enable_n <= en_n;
        end else begin
            o_write_enable_n <= en_n;
        end
        repeat (4) @(posedge i_clock);
        if (rd) begin
            o_read_clock <= 1'b1;
        end else begin
            o_write_clock <= 1'b1;
        end
        repeat (4) @(posedge i_clock);
        o_read_clock  <= 1'b0;
        o_write_clock <= 1'b0;
        repeat (4) @(posedge i_clock);
        // Released data is inverted so a stale word cannot pass as new
        o_write_data        <= ~d;
        o_write_enable_n    <= 1'b1;
        o_read_enable_n     <= 1'b1;
        o_offset_load_sel_n <= 1'b1;
        @(negedge i_clock);
    endtask

    task automatic set_ren(input logic v);
        @(posedge i_clock);
        o_read_enable_n <= v;
        @(negedge i_clock);
    endtask
endmodule

// file: test/tb_top.sv
// Purpose: Self-checking bench for the programmable-flag buffer
// Assumes: Depth of 16 so full and almost-full are reached quickly
// Notes:   Pin accesses come from the controller model; checks at negedge
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sfp_pkg::*;

    localparam int DEPTH = 16;
    localparam int LIMIT = 5000;
    logic        i_clock, i_reset_n, clk_en, drive_en_n, fsync;
    logic        replay, cascaded, wclk, rclk, wen_n, ren_n, ld_n;
    logic        oe_n, ef_n, ff_n, ae_n, af_n, hf_n;
    logic [17:0] wdata, rdata;
    int          checks, fail_count, cycles;

    sfp_agent_model u_sfp_agent_model (
        .i_clock(i_clock), .o_write_clock(wclk), .o_read_clock(rclk),
        .o_write_enable_n(wen_n), .o_read_enable_n(ren_n),
        .o_offset_load_sel_n(ld_n), .o_write_data(wdata));

    sfp_fifo #(.DEPTH(DEPTH)) u_sfp_fifo (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_clock_en(clk_en),
        .i_write_clock(wclk), .i_read_clock(rclk),
        .i_write_enable_n(wen_n), .i_read_enable_n(ren_n),
        .i_offset_load_sel_n(ld_n), .i_output_drive_en_n(drive_en_n),
        .i_flag_sync_select(fsync), .i_replay_strobe(replay),
        .i_cascaded(cascaded), .i_write_data_in(wdata),
        .o_read_data_out(rdata), .o_read_data_oe_n(oe_n),
        .o_empty_flag_n(ef_n), .o_full_flag_n(ff_n),
        .o_almost_empty_flag_n(ae_n), .o_almost_full_flag_n(af_n),
        .o_half_full_flag_n(hf_n));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Flags packed as empty, full, almost empty, almost full, half
    function automatic logic [17:0] fl();
        return 18'({ef_n, ff_n, ae_n, af_n, hf_n});
    endfunction

    function automatic logic [17:0] word(input int i);
        return 18'(i * 5923 + 195);
    endfunction

    task automatic idle(input int n);
        repeat (n) @(posedge i_clock);
        @(negedge i_clock);
    endtask

    task automatic wr(input logic en_n, input logic ld, input logic [17:0] d);
        u_sfp_agent_model.pin_op(1'b0, en_n, ld, d);
    endtask

    task automatic rd(input logic ld);
        u_sfp_agent_model.pin_op(1'b1, 1'b0, ld, '0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        idle(6);
        chk(fl(), 18'h0000B);
        chk(rdata, 18'h00000);
        chk(18'(oe_n), 18'h00000);
        $display("test reset done");
    endtask

    task automatic t_offsets();
        logic [17:0] exp_off [3];
        exp_off = '{18'h00002, 18'h00003, 18'h00002};
        rd(1'b0);
        chk(rdata, 18'h0007F);
        rd(1'b0);
        chk(rdata, 18'h0007F);
        wr(1'b0, 1'b0, 18'h3C002);
        wr(1'b1, 1'b0, 18'h00007);
        wr(1'b0, 1'b0, 18'h00003);
        for (int i = 0; i < 3; i++) begin
            rd(1'b0);
            chk(rdata, exp_off[i]);
        end
        $display("test offsets done");
    endtask

    task automatic t_fill();
        logic [17:0] e;
        @(posedge i_clock);
        fsync <= 1'b1;
        for (int k = 1; k <= DEPTH; k++) begin
            wr(1'b0, 1'b1, word(k - 1));
            e = 18'({1'b0, k != DEPTH, k > 2, k < DEPTH - 3, k <= 8});
            chk(fl(), e);
        end
        wr(1'b0, 1'b1, 18'h3FFFF);
        chk(fl(), 18'h00004);
        $display("test fill done");
    endtask

    task automatic t_drain();
        logic [17:0] e;
        @(posedge i_clock);
        fsync <= 1'b0;
        rd(1'b1);
        chk(rdata, 18'h00002);
        chk(fl() | 18'h1, 18'h00015);
        for (int i = 0; i < DEPTH; i++) begin
            rd(1'b1);
            chk(rdata, word(i));
            e = 18'({i != DEPTH - 1, i > 3, DEPTH - 1 - i > 2, i > 3, 1'b1});
            chk(fl() | 18'h1, e);
            if (i == 3) begin
                wr(1'b1, 1'b1, 18'h00000);
                chk(fl() | 18'h1, e | 18'h0000A);
            end
        end
        rd(1'b1);
        chk(rdata, word(DEPTH - 1));
        chk(fl() | 18'h1, 18'h0000B);
        $display("test drain done");
    endtask

    task automatic t_replay();
        @(posedge i_clock);
        // Both pin clocks stay low through the strobe and recovery
        replay <= 1'b1;
        idle(8);
        @(posedge i_clock);
        replay <= 1'b0;
        idle(8);
        rd(1'b1);
        chk(18'(ef_n), 18'h00001);
        rd(1'b1);
        chk(rdata, word(0));
        rd(1'b1);
        chk(rdata, word(1));
        $display("test replay done");
    endtask

    task automatic t_oe();
        @(posedge i_clock);
        drive_en_n <= 1'b1;
        idle(6);
        chk(18'(oe_n), 18'h00001);
        @(posedge i_clock);
        drive_en_n <= 1'b0;
        cascaded   <= 1'b1;
        idle(6);
        chk(18'(oe_n), 18'h00001);
        u_sfp_agent_model.set_ren(1'b0);
        idle(6);
        chk(18'(oe_n), 18'h00000);
        u_sfp_agent_model.set_ren(1'b1);
        $display("test output enable done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        i_reset_n  = 1'b0;
        clk_en     = 1'b1;
        drive_en_n = 1'b0;
        fsync      = 1'b0;
        replay     = 1'b0;
        cascaded   = 1'b0;
        repeat (8) @(posedge i_clock);
        // Release away from the sampling edge
        @(negedge i_clock);
        i_reset_n = 1'b1;
        t_reset();
        t_offsets();
        t_fill();
        t_drain();
        t_replay();
        t_oe();
        tally_and_finish();
    end
endmodule
